// [design/vfpg_cfg.svh]
// Constants of the voltage/frequency pattern generator
`ifndef VFPG_CFG_SVH
`define VFPG_CFG_SVH
`define VFPG_UNUSED_F 14'h270f
`define VFPG_BV_95PCT 14'h22b8
`define VFPG_BV_SUPPLY 14'h270f
`define VFPG_FMAX 14'h0190
`define VFPG_VMAX 14'h03e8
`define VFPG_LP_CT 14'h0000
`define VFPG_LP_VT 14'h0001
`define VFPG_LP_RST 14'h0001
`define VFPG_AM_STD 14'h0000
`define VFPG_AM_CTM 14'h0001
`define VFPG_AM_5PT 14'h0002
`define VFPG_AM_STD2 14'h0014
`define VFPG_AM_RST 14'h0000
`define VFPG_VOLT_RST 14'h0000
`define VFPG_GRP_OPEN 14'h0000
`define VFPG_SEL_LOAD 4'h0
`define VFPG_SEL_MOTOR 4'h1
`define VFPG_SEL_PT0 4'h2
`define VFPG_SEL_PTN 4'hb
`define VFPG_BOOST_STD 8'h03
`define VFPG_BRAKE_STD 8'h04
`define VFPG_BOOST_CTM 8'h02
`define VFPG_BRAKE_CTM 8'h02
`define VFPG_PCT_95 32'h0000005f
`define VFPG_PCT_100 32'h00000064
`define VFPG_NPTS 5
`endif

// [design/vfpg_pkg.sv]
// Types of the voltage/frequency pattern generator
package vfpg_pkg;
  typedef struct packed {
    logic [3:0] sel;
    logic [13:0] data;
  } vfpg_wr_t;
  typedef struct packed {
    logic [13:0] freq;
    logic [13:0] volt;
  } vfpg_pt_t;
  typedef enum logic [1:0] {
    VFPG_CTRL_VF,
    VFPG_CTRL_OPTEX,
    VFPG_CTRL_SMFV
  } vfpg_ctrl_t;
endpackage

// [design/vfpg_top.sv]
// Voltage/frequency pattern generator with checked setting writes
`timescale 1ns/1ns
`include "vfpg_cfg.svh"
module vfpg_top (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic wr_valid_i,
  input wire vfpg_pkg::vfpg_wr_t wr_i,
  input wire logic [13:0] group_read_select_i,
  input wire logic [13:0] base_voltage_setting_i,
  input wire logic [13:0] base_freq_setting_i,
  input wire logic [13:0] second_base_freq_i,
  input wire logic second_function_input_i,
  input wire logic [13:0] supply_voltage_i,
  input wire logic [13:0] run_freq_i,
  input wire vfpg_pkg::vfpg_ctrl_t ctrl_mode_i,
  input wire logic cap_rating_sel_i,
  output logic [13:0] volt_cmd_o,
  output logic wr_ack_o,
  output logic wr_err_o,
  output logic [13:0] load_pattern_select_o,
  output logic [13:0] applied_motor_type_o,
  output logic thermal_std_o,
  output logic boost_reload_o,
  output logic [7:0] torque_boost_level_o,
  output logic [7:0] dc_brake_voltage_o
);
  // ****************************************
  // Decoding helpers
  // ****************************************
  function automatic logic pt_active(input logic [13:0] f);
    pt_active = (f != `VFPG_UNUSED_F);
  endfunction

  function automatic logic bv_special(input logic [13:0] v);
    bv_special = (v == `VFPG_BV_95PCT) || (v == `VFPG_BV_SUPPLY);
  endfunction

  vfpg_pkg::vfpg_pt_t pts_q [`VFPG_NPTS];
  logic [13:0] lp_q;
  logic [13:0] am_q;

  // ****************************************
  // Write checking
  // ****************************************
  wire is_pt = (wr_i.sel >= `VFPG_SEL_PT0) && (wr_i.sel <= `VFPG_SEL_PTN);
  wire [3:0] pt_off = wr_i.sel - `VFPG_SEL_PT0;
  wire [2:0] pt_idx = pt_off[3:1];
  wire is_volt = pt_off[0];
  wire grp_open = (group_read_select_i == `VFPG_GRP_OPEN);
  wire [`VFPG_NPTS-1:0] dup_vec;
  genvar gi;
  generate
    for (gi = 0; gi < `VFPG_NPTS; gi++) begin : g_dup
      assign dup_vec[gi] = (3'(gi) != pt_idx) &&
        (pts_q[gi].freq == wr_i.data);
    end
  endgenerate
  // Unused marker may repeat; only real frequencies clash
  wire dup_hit = pt_active(wr_i.data) && (|dup_vec);
  wire am_legal = (wr_i.data == `VFPG_AM_STD) ||
    (wr_i.data == `VFPG_AM_CTM) || (wr_i.data == `VFPG_AM_5PT) ||
    (wr_i.data == `VFPG_AM_STD2);
  wire am_block = (wr_i.data == `VFPG_AM_5PT) &&
    bv_special(base_voltage_setting_i);
  wire f_legal = (wr_i.data <= `VFPG_FMAX) || !pt_active(wr_i.data);
  wire v_legal = (wr_i.data <= `VFPG_VMAX);
  wire val_ok = (wr_i.sel == `VFPG_SEL_LOAD) ? (wr_i.data <= `VFPG_LP_VT) :
    (wr_i.sel == `VFPG_SEL_MOTOR) ? (am_legal && !am_block) :
    is_pt ? (is_volt ? v_legal : (f_legal && !dup_hit)) : 1'b0;
  wire wr_take = wr_valid_i && grp_open && val_ok;
  wire am_take = wr_take && (wr_i.sel == `VFPG_SEL_MOTOR);
  wire am_ctm = (wr_i.data == `VFPG_AM_CTM);

  // ****************************************
  // Setting storage
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      lp_q <= `VFPG_LP_RST;
      am_q <= `VFPG_AM_RST;
    end else if (wr_take && (wr_i.sel == `VFPG_SEL_LOAD)) begin
      lp_q <= wr_i.data;
    end else if (am_take) begin
      am_q <= wr_i.data;
    end
  end

  generate
    for (gi = 0; gi < `VFPG_NPTS; gi++) begin : g_pt
      always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
          pts_q[gi].freq <= `VFPG_UNUSED_F;
          pts_q[gi].volt <= `VFPG_VOLT_RST;
        end else if (wr_take && is_pt && (pt_idx == 3'(gi))) begin
          if (is_volt) begin
            pts_q[gi].volt <= wr_i.data;
          end else begin
            pts_q[gi].freq <= wr_i.data;
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // Voltage curve
  // ****************************************
  wire [31:0] sup95 = (32'(supply_voltage_i) * `VFPG_PCT_95) / `VFPG_PCT_100;
  wire [13:0] vbase = (base_voltage_setting_i == `VFPG_BV_95PCT) ?
    sup95[13:0] : (base_voltage_setting_i == `VFPG_BV_SUPPLY) ?
    supply_voltage_i : base_voltage_setting_i;
  wire five_pt = (am_q == `VFPG_AM_5PT) &&
    (ctrl_mode_i != vfpg_pkg::VFPG_CTRL_SMFV);
  wire use_f2 = second_function_input_i && pt_active(second_base_freq_i) &&
    (am_q != `VFPG_AM_5PT);
  wire [13:0] fbase = use_f2 ? second_base_freq_i : base_freq_setting_i;
  wire at_top = (run_freq_i >= fbase);
  wire [31:0] lin_v = (32'(vbase) * 32'(run_freq_i)) / 32'(fbase);
  wire [31:0] sq_v = (32'(vbase) * 32'(run_freq_i) * 32'(run_freq_i)) /
    (32'(fbase) * 32'(fbase));

  logic [13:0] pt_v;
  always_comb begin
    logic [13:0] fl;
    logic [13:0] vl;
    logic [13:0] fu;
    logic [13:0] vu;
    logic [31:0] span;
    fl = 14'h0000;
    vl = 14'h0000;
    fu = fbase;
    vu = vbase;
    span = 32'h00000000;
    // Nearest active point at or below, and above, the running frequency
    for (int i = 0; i < `VFPG_NPTS; i++) begin
      if (pt_active(pts_q[i].freq) && (pts_q[i].freq < fbase)) begin
        if ((pts_q[i].freq <= run_freq_i) && (pts_q[i].freq >= fl)) begin
          fl = pts_q[i].freq;
          vl = pts_q[i].volt;
        end
        if ((pts_q[i].freq > run_freq_i) && (pts_q[i].freq < fu)) begin
          fu = pts_q[i].freq;
          vu = pts_q[i].volt;
        end
      end
    end
    // Magnitude form avoids signed division of a falling segment
    if (vu >= vl) begin
      span = (32'(vu - vl) * 32'(run_freq_i - fl)) / 32'(fu - fl);
      pt_v = vl + span[13:0];
    end else begin
      span = (32'(vl - vu) * 32'(run_freq_i - fl)) / 32'(fu - fl);
      pt_v = vl - span[13:0];
    end
  end

  wire [13:0] volt_d = (at_top || (fbase == 14'h0000)) ? vbase :
    five_pt ? pt_v :
    (lp_q == `VFPG_LP_CT) ? lin_v[13:0] : sq_v[13:0];

  // ****************************************
  // Output registers
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      volt_cmd_o <= 14'h0000;
      wr_ack_o <= 1'b0;
      wr_err_o <= 1'b0;
      thermal_std_o <= 1'b1;
      boost_reload_o <= 1'b0;
      torque_boost_level_o <= `VFPG_BOOST_STD;
      dc_brake_voltage_o <= `VFPG_BRAKE_STD;
    end else begin
      volt_cmd_o <= volt_d;
      wr_ack_o <= wr_take;
      wr_err_o <= wr_valid_i && !wr_take;
      thermal_std_o <= (am_q != `VFPG_AM_CTM);
      boost_reload_o <= am_take && cap_rating_sel_i;
      if (am_take && cap_rating_sel_i) begin
        torque_boost_level_o <= am_ctm ? `VFPG_BOOST_CTM : `VFPG_BOOST_STD;
        dc_brake_voltage_o <= am_ctm ? `VFPG_BRAKE_CTM : `VFPG_BRAKE_STD;
      end
    end
  end
  assign load_pattern_select_o = lp_q;
  assign applied_motor_type_o = am_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_am2_req;
    wr_valid_i && (wr_i.sel == `VFPG_SEL_MOTOR) &&
      (wr_i.data == `VFPG_AM_5PT) && bv_special(base_voltage_setting_i);
  endsequence
  sequence s_am_kept;
    wr_err_o && !wr_ack_o && (am_q == $past(am_q));
  endsequence

  a_grp_write_lock: assert property (wr_ack_o |->
    $past(group_read_select_i) == `VFPG_GRP_OPEN)
    else $error("write taken while group select closed");
  a_am2_refused: assert property (s_am2_req |=> s_am_kept)
    else $error("motor type 2 taken with special base voltage");
  a_dup_refused: assert property (wr_valid_i && is_pt &&
    !is_volt && dup_hit |=> wr_err_o && !wr_ack_o)
    else $error("duplicate point frequency accepted");
  a_boost_reload: assert property (am_take && cap_rating_sel_i |=>
    boost_reload_o && (torque_boost_level_o ==
    (($past(wr_i.data) == `VFPG_AM_CTM) ?
    `VFPG_BOOST_CTM : `VFPG_BOOST_STD)) &&
    (dc_brake_voltage_o == (($past(wr_i.data) == `VFPG_AM_CTM) ?
    `VFPG_BRAKE_CTM : `VFPG_BRAKE_STD)))
    else $error("torque boost or brake voltage not reloaded");
  a_thermal_std: assert property (am_q == `VFPG_AM_5PT ##1
    am_q == `VFPG_AM_5PT |-> thermal_std_o)
    else $error("thermal model not standard for motor type 2");
  a_top_voltage: assert property (at_top |=>
    volt_cmd_o == $past(vbase))
    else $error("voltage not at base above base frequency");
  a_second_ignored: assert property (am_q == `VFPG_AM_5PT |->
    fbase == base_freq_setting_i)
    else $error("second base frequency used with motor type 2");
  a_smfv_no_curve: assert property ((ctrl_mode_i ==
    vfpg_pkg::VFPG_CTRL_SMFV) && !at_top && (fbase != 14'h0000) &&
    (lp_q == `VFPG_LP_CT) |=> volt_cmd_o == $past(lin_v[13:0]))
    else $error("five-point curve active under flux vector control");
endmodule

// [verification/vfpg_stage_model.sv]
// Behavioural power output stage fed by the voltage command
`timescale 1ns/1ns
module vfpg_stage_model (
  input wire logic sys_clk_i,
  input wire logic [13:0] volt_cmd_i,
  output logic [13:0] motor_volt_o
);
  // ****************************************
  // Output stage
  // ****************************************
  // Applies the command one edge late, as a switching stage would
  always_ff @(posedge sys_clk_i) begin
    motor_volt_o <= volt_cmd_i;
  end
endmodule

// [verification/vfpg_top_tb.sv]
// Self-checking testbench of the voltage/frequency pattern generator
`timescale 1ns/1ns
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  miscompares++; $display("[FAIL] %s exp %0d got %0d", n, e, g); end end
module vfpg_top_tb;
  // ****************************************
  // Stimulus and checks
  // ****************************************
  logic sys_clk_i = 1'b0, nrst_i = 1'b0, wr_valid = 1'b0, sfi = 1'b0;
  logic cap = 1'b0, th_std, reload;
  vfpg_pkg::vfpg_wr_t wr_s = '0;
  vfpg_pkg::vfpg_ctrl_t ctrl = vfpg_pkg::VFPG_CTRL_VF;
  logic [13:0] grp = 14'h0000, bv = 14'h00c8, bf = 14'h003c;
  logic [13:0] sbf = 14'h270f, sup = 14'h00dc, rf = 14'h0000;
  logic [13:0] volt, lp, mt_o, motor_v;
  logic ack, err;
  logic [7:0] boost, brake;
  int miscompares = 0, check_count = 0, cycles = 0;
  logic [13:0] mt [4] = '{14'h0001, 14'h0014, 14'h0001, 14'h0000};
  logic [7:0] bo [4] = '{8'h02, 8'h03, 8'h02, 8'h03};
  logic [7:0] br [4] = '{8'h02, 8'h04, 8'h02, 8'h04};
  always #4 sys_clk_i = ~sys_clk_i;
  vfpg_top dut_u (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .wr_valid_i(wr_valid), .wr_i(wr_s), .group_read_select_i(grp),
    .base_voltage_setting_i(bv), .base_freq_setting_i(bf),
    .second_base_freq_i(sbf), .second_function_input_i(sfi),
    .supply_voltage_i(sup), .run_freq_i(rf), .ctrl_mode_i(ctrl),
    .cap_rating_sel_i(cap), .volt_cmd_o(volt), .wr_ack_o(ack),
    .wr_err_o(err), .load_pattern_select_o(lp),
    .applied_motor_type_o(mt_o), .thermal_std_o(th_std),
    .boost_reload_o(reload), .torque_boost_level_o(boost),
    .dc_brake_voltage_o(brake));
  vfpg_stage_model stage_u (.sys_clk_i(sys_clk_i), .volt_cmd_i(volt),
    .motor_volt_o(motor_v));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // One write, answer sampled in the single cycle it stands
  task automatic put(input logic [3:0] s, input logic [13:0] d,
    input logic ok);
    @(negedge sys_clk_i);
    wr_valid = 1'b1;
    wr_s.sel = s;
    wr_s.data = d;
    @(negedge sys_clk_i);
    wr_valid = 1'b0;
    `CHK("ack", ok, ack)
    `CHK("err", !ok, err)
  endtask
  task automatic vchk(input logic [13:0] f, input logic [13:0] e);
    @(negedge sys_clk_i);
    rf = f;
    @(negedge sys_clk_i);
    `CHK("volt", e, volt)
  endtask
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      stop_test();
    end
  end
  initial begin
    repeat (3) @(negedge sys_clk_i);
    nrst_i = 1'b1;
    `CHK("pattern", 14'h0001, lp)
    `CHK("motor", 14'h0000, mt_o)
    `CHK("boost", 8'h03, boost)
    `CHK("brake", 8'h04, brake)
    vchk(14'h001e, 14'h0032);
    vchk(14'h003c, 14'h00c8);
    vchk(14'h0046, 14'h00c8);
    put(4'h0, 14'h0000, 1'b1);
    vchk(14'h001e, 14'h0064);
    vchk(14'h000f, 14'h0032);
    grp = 14'h0001;
    put(4'h0, 14'h0001, 1'b0);
    put(4'h2, 14'h0014, 1'b0);
    grp = 14'h0000;
    `CHK("pattern", 14'h0000, lp)
    put(4'h0, 14'h0002, 1'b0);
    put(4'h1, 14'h0003, 1'b0);
    put(4'hc, 14'h0000, 1'b0);
    cap = 1'b1;
    for (int i = 0; i < 4; i++) begin
      put(4'h1, mt[i], 1'b1);
      `CHK("reload", 1'b1, reload)
      `CHK("boost", bo[i], boost)
      `CHK("brake", br[i], brake)
    end
    cap = 1'b0;
    put(4'h1, 14'h0001, 1'b1);
    @(negedge sys_clk_i);
    `CHK("boost", 8'h03, boost)
    `CHK("thermal", 1'b0, th_std)
    put(4'h6, 14'h0191, 1'b0);
    put(4'h6, 14'h0190, 1'b1);
    put(4'h6, 14'h270f, 1'b1);
    put(4'h7, 14'h03e9, 1'b0);
    put(4'h2, 14'h0014, 1'b1);
    put(4'h4, 14'h0014, 1'b0);
    put(4'h4, 14'h0028, 1'b1);
    put(4'h3, 14'h0064, 1'b1);
    put(4'h5, 14'h0078, 1'b1);
    bv = 14'h270f;
    put(4'h1, 14'h0002, 1'b0);
    bv = 14'h22b8;
    put(4'h1, 14'h0002, 1'b0);
    `CHK("motor", 14'h0001, mt_o)
    bv = 14'h00c8;
    put(4'h1, 14'h0002, 1'b1);
    @(negedge sys_clk_i);
    `CHK("motor", 14'h0002, mt_o)
    `CHK("thermal", 1'b1, th_std)
    vchk(14'h000a, 14'h0032);
    vchk(14'h001e, 14'h006e);
    vchk(14'h0032, 14'h00a0);
    ctrl = vfpg_pkg::VFPG_CTRL_SMFV;
    vchk(14'h000a, 14'h0021);
    ctrl = vfpg_pkg::VFPG_CTRL_OPTEX;
    vchk(14'h000a, 14'h0032);
    ctrl = vfpg_pkg::VFPG_CTRL_VF;
    sbf = 14'h001e;
    sfi = 1'b1;
    vchk(14'h000f, 14'h004b);
    put(4'h1, 14'h0000, 1'b1);
    vchk(14'h000f, 14'h0064);
    sfi = 1'b0;
    bv = 14'h270f;
    vchk(14'h003c, 14'h00dc);
    bv = 14'h22b8;
    vchk(14'h003c, 14'h00d1);
    @(negedge sys_clk_i);
    `CHK("stage", 14'h00d1, motor_v)
    stop_test();
  end
endmodule
